// ===== rtl/ect_top.sv
// 16-bit timer and event counter with preload and byte-buffered access
//
// Function
// - 16-bit up-counter, three counting modes plus idle
// - Writes load preload, reads return counter
// - Timer and pulse modes use clock/4
// - Event mode counts one per chosen edge
// - Past FFFF: interrupt, reload preload, continue
// - Stopped counter takes written preload at once
// - Running counter takes preload at overflow only
// - Low write buffered, high write commits both
// - High read captures low byte for later
// - Preload zero gives full-range count
// - Preload undefined until software writes it
// - Control bit 4 runs or halts counting
// - Control bit 3 selects active edge
// - Mode bits 1,0 select interval timer
// - Timer mode counts each internal clock fall
// - Interrupt enable low blocks overflow interrupt
// - Mode bits 0,1 select event counting
// - Edge bit low rising, high falling
// - Pulse mode counts while pin not idle
// - Pulse end clears run, pin ignored after
//
// Register map
// Index 0: count_low_byte, writes buffered, reads the hold byte
// Index 1: count_high_byte, write commits preload, read captures low
// Index 2: counter_control, mode, run and edge fields
// Index 3: interrupt_control, enable and sticky overflow flag
// All four indices decoded, nothing refused
// Strobes one cycle, back to back allowed
//
// counter_control fields
// Bit 7: mode_sel_hi
// Bit 6: mode_sel_lo
// Bit 4: run_enable
// Bit 3: edge_polarity
// Bits 5, 2, 1, 0: reserved, read as zero
//
// interrupt_control fields
// Bit 0: overflow_irq_enable
// Bit 1: overflow flag, sticky, cleared by writing zero
// Bits 7 to 2: reserved, read as zero
//
// Modes, mode_sel_hi then mode_sel_lo
// 00: idle, no counting
// 01: event counting on pin edges
// 10: interval timer on the divided clock
// 11: pulse width on the divided clock
//
// Event counting
// Edge bit low counts rising edges
// Edge bit high counts falling edges
// One step per synchronised transition
//
// Pulse width measurement
// Edge bit low: idle high, counts while pin low
// Edge bit high: idle low, counts while pin high
// Return to idle clears run_enable
// Pin then ignored until software sets run again
//
// Overflow
// Step from full count reloads the preload value
// Flag sets whether or not the interrupt is enabled
// Enable gates only the request output
//
// Timing
// Divided clock tick once every DIV_RATIO system clocks
// Pin edges seen two clocks after the raw pin moves
// Read data valid in the cycle after the strobe only
// Interrupt request one cycle, one clock after overflow
//
// Reset
// Control, enable, flag, divider and pin stages cleared
// Read data and interrupt request held low
//
// Hazards and limits
// Count byte access drops a step in that cycle
// Dropped steps are lost, not deferred
// Counter, preload and hold byte have no reset
// Load a value before setting run_enable
// Run written with a high byte: load uses old run
// Software control write beats automatic run clear
// Overflow and flag clear together: flag stays set
// Pin high at reset release looks like a rise
// That false rise is harmless while run_enable is low
`timescale 1ns/1ps
`default_nettype none

module ect_top #(
    parameter int DIV_RATIO = ect_pkg::CLK_DIV_RATIO
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [ect_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ect_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [ect_pkg::DATA_W-1:0] reg_rdata,
    // Shared timer input pin
    input wire logic external_event_pin,
    // Overflow interrupt request
    output logic timer_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    // Events between pin stage, divider and core
    ect_evt_if evt_bus ();

    // Count, preload and hold byte
    logic [ect_pkg::COUNT_W-1:0] count;
    logic [ect_pkg::COUNT_W-1:0] preload;
    logic [ect_pkg::DATA_W-1:0] low_hold;

    // Control and interrupt fields
    logic run_enable;
    logic edge_polarity;
    ect_pkg::ect_mode_type mode;
    logic overflow_irq_enable;
    logic overflow_flag;

    // Decoded register strobes
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic wr_irq;
    logic rd_low;
    logic rd_high;
    logic access_inhibit;

    // Count qualification terms
    logic active_edge;
    logic return_edge;
    logic pin_active;
    logic pulse_done;
    logic next_advance;
    logic count_full;
    logic overflow;
    logic [ect_pkg::COUNT_W-1:0] write_word;

    ////////////////////////////////////////////////////////////////////////
    // Pin events and internal timer clock

    // Pin synchroniser and edge detector
    ect_pin_sync u_pin_sync (
        .clk(clk),
        .rstn(rstn),
        .pin_raw(external_event_pin),
        .evt(evt_bus.pin_src)
    );

    // System clock divider
    ect_prescaler #(
        .DIV_RATIO(DIV_RATIO)
    ) u_prescaler (
        .clk(clk),
        .rstn(rstn),
        .evt(evt_bus.tick_src)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    // Write strobes per register
    always_comb begin
        wr_low = 1'b0;
        wr_high = 1'b0;
        wr_ctrl = 1'b0;
        wr_irq = 1'b0;
        if (reg_write && reg_addr == ect_pkg::OFS_COUNT_LOW) begin
            wr_low = 1'b1;
        end else if (reg_write && reg_addr == ect_pkg::OFS_COUNT_HIGH) begin
            wr_high = 1'b1;
        end else if (reg_write && reg_addr == ect_pkg::OFS_CONTROL) begin
            wr_ctrl = 1'b1;
        end else if (reg_write && reg_addr == ect_pkg::OFS_IRQ_CONTROL) begin
            wr_irq = 1'b1;
        end
    end

    // Read strobes for the count bytes
    assign rd_low = reg_read && (reg_addr == ect_pkg::OFS_COUNT_LOW);
    assign rd_high = reg_read && (reg_addr == ect_pkg::OFS_COUNT_HIGH);

    // Count clock held off during any count byte access
    assign access_inhibit = wr_low | wr_high | rd_low | rd_high;

    // Word formed by a high byte write and the buffered low byte
    assign write_word = {reg_wdata, low_hold};

    ////////////////////////////////////////////////////////////////////////
    // Count qualification

    // Edge chosen by edge_polarity: low rising, high falling
    assign active_edge = edge_polarity ? evt_bus.pin_fall : evt_bus.pin_rise;

    // Edge returning the pin to its idle level
    assign return_edge = edge_polarity ? evt_bus.pin_fall : evt_bus.pin_rise;

    // Pin away from idle: idle high when edge low, idle low when edge high
    assign pin_active = edge_polarity ? evt_bus.pin_level : ~evt_bus.pin_level;

    // Pulse finished while measuring
    assign pulse_done = (mode == ect_pkg::MODE_PULSE) && run_enable && return_edge;

    // Whether the counter steps in this cycle
    always_comb begin
        next_advance = 1'b0;
        case (mode)
            ect_pkg::MODE_TIMER: begin
                next_advance = run_enable & evt_bus.tick;
            end
            ect_pkg::MODE_EVENT: begin
                next_advance = run_enable & active_edge;
            end
            ect_pkg::MODE_PULSE: begin
                next_advance = run_enable & evt_bus.tick & pin_active;
            end
            default: begin
                next_advance = 1'b0;
            end
        endcase
        if (access_inhibit) begin
            next_advance = 1'b0;
        end
    end

    // Overflow when stepping from full count
    assign count_full = (count == ect_pkg::COUNT_FULL);
    assign overflow = next_advance & count_full;

    ////////////////////////////////////////////////////////////////////////
    // Counter, preload and byte buffer (no reset: undefined until written)

    // Preload loaded only by a high byte write
    always_ff @(posedge clk) begin
        if (wr_high) begin
            preload <= write_word;
        end
    end

    // Counter: direct load when stopped, else count and reload
    always_ff @(posedge clk) begin
        if (wr_high && !run_enable) begin
            count <= write_word;
        end else if (next_advance) begin
            if (count_full) begin
                count <= preload;
            end else begin
                count <= count + ect_pkg::COUNT_STEP;
            end
        end
    end

    // Low byte buffer shared by writes and high byte reads
    always_ff @(posedge clk) begin
        if (wr_low) begin
            low_hold <= reg_wdata;
        end else if (rd_high) begin
            low_hold <= count[ect_pkg::DATA_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register

    // Software write wins over the automatic run clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            run_enable <= ect_pkg::RST_RUN_ENABLE;
            edge_polarity <= ect_pkg::RST_EDGE_POLARITY;
            mode <= ect_pkg::MODE_IDLE;
        end else if (wr_ctrl) begin
            run_enable <= reg_wdata[ect_pkg::BIT_RUN_ENABLE];
            edge_polarity <= reg_wdata[ect_pkg::BIT_EDGE_POLARITY];
            mode <= ect_pkg::ect_mode_type'({reg_wdata[ect_pkg::BIT_MODE_SEL_HI],
                reg_wdata[ect_pkg::BIT_MODE_SEL_LO]});
        end else if (pulse_done) begin
            run_enable <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt control and request

    // Enable bit and sticky overflow flag, set wins over clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            overflow_irq_enable <= ect_pkg::RST_IRQ_ENABLE;
            overflow_flag <= ect_pkg::RST_IRQ_FLAG;
        end else begin
            if (wr_irq) begin
                overflow_irq_enable <= reg_wdata[ect_pkg::BIT_IRQ_ENABLE];
            end
            if (overflow) begin
                overflow_flag <= 1'b1;
            end else if (wr_irq && !reg_wdata[ect_pkg::BIT_IRQ_FLAG]) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // One-cycle request per overflow, gated by the enable
    always_ff @(posedge clk) begin
        if (!rstn) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= overflow & overflow_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid only in the cycle after the strobe

    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= ect_pkg::RST_RDATA;
        end else if (!reg_read) begin
            reg_rdata <= ect_pkg::READ_ZERO;
        end else if (reg_addr == ect_pkg::OFS_COUNT_LOW) begin
            reg_rdata <= low_hold;
        end else if (reg_addr == ect_pkg::OFS_COUNT_HIGH) begin
            reg_rdata <= count[ect_pkg::COUNT_W-1:ect_pkg::DATA_W];
        end else if (reg_addr == ect_pkg::OFS_CONTROL) begin
            reg_rdata <= ect_pkg::READ_ZERO;
            reg_rdata[ect_pkg::BIT_MODE_SEL_HI] <= mode[1];
            reg_rdata[ect_pkg::BIT_MODE_SEL_LO] <= mode[0];
            reg_rdata[ect_pkg::BIT_RUN_ENABLE] <= run_enable;
            reg_rdata[ect_pkg::BIT_EDGE_POLARITY] <= edge_polarity;
        end else begin
            reg_rdata <= ect_pkg::READ_ZERO;
            reg_rdata[ect_pkg::BIT_IRQ_ENABLE] <= overflow_irq_enable;
            reg_rdata[ect_pkg::BIT_IRQ_FLAG] <= overflow_flag;
        end
    end

endmodule : ect_top

`default_nettype wire

// ===== rtl/ect_pkg.sv
// Constants and types shared by the event timer files
package ect_pkg;

    // Bus widths
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 16;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_COUNT_LOW = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH = 2'h1;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 2'h2;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL = 2'h3;

    // Field positions of counter_control
    localparam int BIT_MODE_SEL_HI = 7;
    localparam int BIT_MODE_SEL_LO = 6;
    localparam int BIT_RUN_ENABLE = 4;
    localparam int BIT_EDGE_POLARITY = 3;

    // Field positions of interrupt_control
    localparam int BIT_IRQ_ENABLE = 0;
    localparam int BIT_IRQ_FLAG = 1;

    // Reset values
    localparam logic RST_RUN_ENABLE = 1'b0;
    localparam logic RST_EDGE_POLARITY = 1'b0;
    localparam logic RST_IRQ_ENABLE = 1'b0;
    localparam logic RST_IRQ_FLAG = 1'b0;
    localparam logic RST_PIN_LEVEL = 1'b0;
    localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    // Timing
    localparam int CLK_DIV_RATIO = 4;
    localparam logic [COUNT_W-1:0] COUNT_FULL = 16'hFFFF;
    localparam logic [COUNT_W-1:0] COUNT_STEP = 16'h0001;

    // Operating modes, {mode_sel_hi, mode_sel_lo}
    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_EVENT = 2'b01,
        MODE_TIMER = 2'b10,
        MODE_PULSE = 2'b11
    } ect_mode_type;

endpackage : ect_pkg

// ===== rtl/ect_evt_if.sv
// Interface carrying pin events and the divided clock tick
`timescale 1ns/1ps
`default_nettype none

interface ect_evt_if;
    logic pin_level;
    logic pin_rise;
    logic pin_fall;
    logic tick;

    // Pin synchroniser side
    modport pin_src (output pin_level, output pin_rise, output pin_fall);
    // Prescaler side
    modport tick_src (output tick);
    // Counter core side
    modport core (input pin_level, input pin_rise, input pin_fall, input tick);
endinterface : ect_evt_if

`default_nettype wire

// ===== rtl/ect_pin_sync.sv
// Synchroniser and edge detector for the external event pin
`timescale 1ns/1ps
`default_nettype none

module ect_pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Raw pin
    input wire logic pin_raw,
    // Clean events
    ect_evt_if.pin_src evt
);

    logic meta;
    logic stable;
    logic last;

    // Two-stage synchroniser then one history stage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta <= ect_pkg::RST_PIN_LEVEL;
            stable <= ect_pkg::RST_PIN_LEVEL;
            last <= ect_pkg::RST_PIN_LEVEL;
        end else begin
            meta <= pin_raw;
            stable <= meta;
            last <= stable;
        end
    end

    // Edges seen only on synchronised stages, one per transition
    assign evt.pin_level = stable;
    assign evt.pin_rise = stable & ~last;
    assign evt.pin_fall = ~stable & last;

endmodule : ect_pin_sync

`default_nettype wire

// ===== rtl/ect_prescaler.sv
// Divider giving the internal timer clock as an enable pulse
`timescale 1ns/1ps
`default_nettype none

module ect_prescaler #(
    parameter int DIV_RATIO = ect_pkg::CLK_DIV_RATIO
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Tick out
    ect_evt_if.tick_src evt
);

    localparam int CNT_W = (DIV_RATIO > 1) ? $clog2(DIV_RATIO) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIV_RATIO - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    logic [CNT_W-1:0] div_count;

    // Free-running divide-by-ratio counter
    always_ff @(posedge clk) begin
        if (!rstn) begin
            div_count <= CNT_ZERO;
        end else if (div_count == CNT_LAST) begin
            div_count <= CNT_ZERO;
        end else begin
            div_count <= div_count + CNT_ONE;
        end
    end

    // Pulse marks the falling transition of the divided clock
    assign evt.tick = (div_count == CNT_LAST);

endmodule : ect_prescaler

`default_nettype wire

// ===== tb/ect_assertions.sv
// Checker for the timer register port and interrupt
`timescale 1ns/1ps
`default_nettype none
module ect_checker #(
    parameter int DIV_RATIO = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Pin and interrupt
    input wire logic external_event_pin,
    input wire logic timer_irq
);
    logic [7:0] ctl_q;
    logic irq_en_q;
    // Mirror of control and enable as software wrote them
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctl_q <= 8'h00;
            irq_en_q <= 1'b0;
        end else if (reg_write && reg_addr == 2'h2) begin
            ctl_q <= reg_wdata;
        end else if (reg_write && reg_addr == 2'h3) begin
            irq_en_q <= reg_wdata[0];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_irq_pulse: assert property (timer_irq |=> !timer_irq)
        else $error("interrupt longer than one cycle");
    a_irq_masked: assert property (timer_irq |-> irq_en_q || $past(irq_en_q))
        else $error("interrupt while disabled");
    a_ctrl_readback: assert property (reg_read && reg_addr == 2'h2 && ctl_q[7:6] != 2'b11
        |=> reg_rdata == (ctl_q & 8'hD8)) else $error("control read back wrong");
    a_irqctl_read: assert property (reg_read && reg_addr == 2'h3
        |=> reg_rdata[7:2] == 6'h00 && reg_rdata[0] == $past(irq_en_q))
        else $error("interrupt control read back wrong");
    a_low_buffer: assert property (reg_write && reg_addr == 2'h0 ##1 reg_read && reg_addr == 2'h0
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("low byte buffer lost");
    a_stopped_load: assert property (!ctl_q[4] && reg_write && reg_addr == 2'h1
        ##1 reg_read && reg_addr == 2'h1 |=> reg_rdata == $past(reg_wdata, 2))
        else $error("halted counter not loaded");
    a_halt_quiet: assert property (!ctl_q[4] [*3] |-> !timer_irq)
        else $error("interrupt while halted");
    c_irq: cover property (timer_irq);
    c_pair: cover property (reg_write && reg_addr == 2'h0 ##1 reg_write && reg_addr == 2'h1);
    c_pulse: cover property (ctl_q[7:6] == 2'b11 && ctl_q[4]);
    c_event: cover property (ctl_q[7:6] == 2'b01 && ctl_q[4] && $rose(external_event_pin));
endmodule : ect_checker
bind ect_top ect_checker #(.DIV_RATIO(DIV_RATIO)) i_ect_checker (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .external_event_pin(external_event_pin), .timer_irq(timer_irq));
`default_nettype wire

// ===== tb/ect_pin_model.sv
// Model of the pulse source on the shared timer pin
`timescale 1ns/1ps
`default_nettype none
module ect_pin_model (
    // Clock
    input wire logic clk,
    // Pin drive
    output var logic pin
);
    initial pin = 1'b0;
    // Hold a level for a number of clocks
    task automatic hold(input logic lvl, input int n);
        pin <= lvl;
        repeat (n) @(posedge clk);
    endtask : hold
    // Pulses away from the idle level
    task automatic pulses(input logic idle, input int n, input int w);
        repeat (n) begin
            hold(~idle, w);
            hold(idle, w);
        end
    endtask : pulses
endmodule : ect_pin_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the 16-bit event timer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic pin;
    logic timer_irq;
    logic [7:0] rdat;
    logic [7:0] v;
    int k;
    int n_mismatch = 0;
    int n_tests = 0;
    ect_top #(.DIV_RATIO(4)) i_ect_top (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .external_event_pin(pin), .timer_irq(timer_irq));
    ect_pin_model i_ect_pin_model (.clk(clk), .pin(pin));
    // Clock
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One bus cycle; keeps the answer of the previous read
    task automatic acc(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
        reg_write <= w;
        reg_read <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        rdat = reg_rdata;
    endtask : acc
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic rd(input logic [1:0] a);
        acc(1'b0, 1'b1, a, 8'h00);
        acc(1'b0, 1'b0, a, 8'h00);
    endtask : rd
    task automatic step(input int n);
        repeat (n) acc(1'b0, 1'b0, 2'h0, 8'h00);
    endtask : step
    // Cycles until the next interrupt pulse, bounded
    task automatic wait_irq;
        k = 0;
        do begin
            step(1);
            k++;
            if (k > 40) begin
                n_mismatch++;
                $display("mismatch at %0t: interrupt wait timed out", $time);
                conclude;
            end
        end while (timer_irq !== 1'b1);
    endtask : wait_irq
    ////////////////////////////////////////////////////////////////
    task automatic t_load;
        wr(2'h2, 8'h80);
        wr(2'h0, 8'h34);
        wr(2'h1, 8'h12);
        rd(2'h1);
        chk(rdat, 8'h12);
        rd(2'h0);
        chk(rdat, 8'h34);
        wr(2'h0, 8'h56);
        rd(2'h0);
        chk(rdat, 8'h56);
        rd(2'h1);
        chk(rdat, 8'h12);
        rd(2'h0);
        chk(rdat, 8'h34);
        wr(2'h2, 8'h10);
        step(12);
        rd(2'h1);
        chk(rdat, 8'h12);
    endtask : t_load
    task automatic t_regs;
        wr(2'h2, 8'hEF);
        rd(2'h2);
        chk(rdat, 8'hC8);
        wr(2'h3, 8'hFF);
        rd(2'h3);
        chk(rdat, 8'h01);
    endtask : t_regs
    task automatic t_timer;
        wr(2'h2, 8'h80);
        wr(2'h0, 8'hFF);
        wr(2'h1, 8'hFF);
        wr(2'h2, 8'h90);
        wait_irq;
        wait_irq;
        chk(8'(k), 8'(ect_pkg::CLK_DIV_RATIO));
        wr(2'h0, 8'h00);
        wr(2'h1, 8'h10);
        rd(2'h1);
        chk(rdat, 8'hFF);
        wait_irq;
        wr(2'h2, 8'h80);
        rd(2'h1);
        chk(rdat, 8'h10);
        rd(2'h3);
        chk(rdat, 8'h03);
        wr(2'h3, 8'h00);
        wr(2'h0, 8'hFF);
        wr(2'h1, 8'hFF);
        wr(2'h2, 8'h90);
        v = 8'h00;
        repeat (20) begin
            step(1);
            if (timer_irq !== 1'b0) v++;
        end
        chk(v, 8'h00);
        wr(2'h2, 8'h80);
        rd(2'h3);
        chk(rdat, 8'h02);
    endtask : t_timer
    task automatic t_event;
        wr(2'h0, 8'h00);
        wr(2'h1, 8'h00);
        wr(2'h2, 8'h50);
        step(1);
        i_ect_pin_model.pulses(1'b0, 5, 3);
        step(6);
        rd(2'h1);
        rd(2'h0);
        chk(rdat, 8'h05);
        wr(2'h2, 8'h58);
        step(1);
        i_ect_pin_model.pulses(1'b0, 3, 3);
        step(6);
        rd(2'h1);
        rd(2'h0);
        chk(rdat, 8'h08);
    endtask : t_event
    task automatic t_pulse;
        i_ect_pin_model.hold(1'b1, 4);
        wr(2'h2, 8'h80);
        wr(2'h0, 8'h00);
        wr(2'h1, 8'h00);
        wr(2'h2, 8'hD0);
        step(1);
        i_ect_pin_model.hold(1'b0, 40);
        i_ect_pin_model.hold(1'b1, 8);
        rd(2'h2);
        chk(rdat, 8'hC0);
        rd(2'h1);
        chk(rdat, 8'h00);
        rd(2'h0);
        v = rdat;
        chk(8'(v >= 8'h09 && v <= 8'h0B), 8'h01);
        i_ect_pin_model.hold(1'b0, 20);
        i_ect_pin_model.hold(1'b1, 8);
        rd(2'h1);
        rd(2'h0);
        chk(rdat, v);
    endtask : t_pulse
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        step(1);
        t_load;
        t_regs;
        t_timer;
        t_event;
        t_pulse;
        conclude;
    end
endmodule : tb
`default_nettype wire
